// ---- adcseq_regs.vh ----
// Register offsets, field positions, reset values and timing of the sequencer
`ifndef ADCSEQ_REGS_VH
`define ADCSEQ_REGS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define ADCSEQ_CTRL_OFS      8'h00
`define ADCSEQ_PRELOAD_OFS   8'h04
`define ADCSEQ_STATUS_OFS    8'h08
`define ADCSEQ_TIMER_OFS     8'h0c

// ------------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------------
`define ADCSEQ_SRC_LSB       0
`define ADCSEQ_SRC_MSB       1
`define ADCSEQ_CNT_LSB       2
`define ADCSEQ_CNT_MSB       4
`define ADCSEQ_TWOCH_BIT     5
`define ADCSEQ_GAP_LSB       8
`define ADCSEQ_GAP_MSB       11
`define ADCSEQ_GO_BIT        16
`define ADCSEQ_RUN_BIT       17

// ------------------------------------------------------------------
// Status register fields (write one to clear where noted)
// ------------------------------------------------------------------
`define ADCSEQ_ST_OVR_BIT    2
`define ADCSEQ_ST_IRQ_BIT    3

// ------------------------------------------------------------------
// Encodings and reset values
// ------------------------------------------------------------------
`define ADCSEQ_SRC_DELAY     2'b10
`define ADCSEQ_SRC_FREE      2'b11
`define ADCSEQ_CNT_MANUAL    3'b000
`define ADCSEQ_SRC_RST       2'b00
`define ADCSEQ_CNT_RST       3'b000
`define ADCSEQ_GAP_RST       4'h0
`define ADCSEQ_PRELOAD_RST   16'h0000
`define ADCSEQ_TIMER_FULL    16'hffff

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define ADCSEQ_CLK_NS        40
`define ADCSEQ_GAP_UNIT_NS   160

`endif

// ---- adcseq_delay_timer.v ----
// Sixteen-bit up-counting delay timer with preload and overflow pulse
`timescale 1ns/100ps
`default_nettype none

`include "adcseq_regs.vh"

module adcseq_delay_timer #(
  parameter WIDTH = 16
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             run,
  input  wire             load,
  input  wire [WIDTH-1:0] load_value,
  input  wire [WIDTH-1:0] preload,
  output wire [WIDTH-1:0] count,
  output wire             overflow
);

  reg [WIDTH-1:0] cnt;

  // ------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------
  assign count    = cnt;
  assign overflow = run && (cnt == {WIDTH{1'b1}});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= `ADCSEQ_PRELOAD_RST;
    end else if (load) begin
      // A load wins over overflow reload and counting; the sequencer only loads while stopped
      cnt <= load_value;
    end else if (overflow) begin
      cnt <= preload;
    end else if (run) begin
      cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // adcseq_delay_timer

`default_nettype wire

// ---- adcseq_gap_timer.v ----
// Programmable gap between conversions, in units of a fixed cycle count
`timescale 1ns/100ps
`default_nettype none

`include "adcseq_regs.vh"

module adcseq_gap_timer #(
  parameter UNIT_CYCLES = 4
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       run,
  input  wire [3:0] gap,
  output wire       done
);

  localparam [9:0] UNIT = UNIT_CYCLES;

  reg  [9:0] cnt;
  wire [9:0] target;

  // ------------------------------------------------------------------
  // Gap length is (gap + 1) units so a zero code still separates
  // ------------------------------------------------------------------
  assign target = ({6'h00, gap} + 10'h001) * UNIT;
  assign done   = run && (cnt == target - 10'h001);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 10'h000;
    end else if (!run || done) begin
      cnt <= 10'h000;
    end else begin
      cnt <= cnt + 10'h001;
    end
  end

endmodule // adcseq_gap_timer

`default_nettype wire

// ---- adcseq_sequencer.v ----
// Automatic conversion sequencer with APB registers, top level
// Operation
// - Source 10 with nonzero count: go bit enables timer-delayed conversions
// - Source 10: setting go bit also sets timer run bit at once
// - Delay counter counts from preload to ffff; overflow starts conversion
// - After overflow counter reloads preload; each overflow while waiting starts next one
// - Source 10 done after N: clear run and go, set interrupt flag
// - Count select picks N from 1, 2, 4, 8 or 16
// - No new start while go bit is high; only after N done or a stop
// - Interrupt stays raised if all conversions finished before go cleared
// - Go rising clears overrun flag; in source 10 sets run bit too
// - Overflow during work sets overrun, is ignored, work completes
// - Two-channel source 10: overflow starts ch1, gap, ch2, then wait
// - Source 11: go starts conversion at once, then gap after each
// - Source 11 done after N: clear only go, set interrupt flag
// - Source 11 go cleared: reset after busy falls, or at once if idle
// - Two-channel source 11: gap after ch2, then next pair until N
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

`include "adcseq_regs.vh"

module adcseq_sequencer #(
  parameter GAP_UNIT_NS = `ADCSEQ_GAP_UNIT_NS,
  parameter CLK_NS      = `ADCSEQ_CLK_NS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        conv_busy_pin,
  output reg         conv_start,
  output reg         conv_channel,
  output reg         adc_irq
);

  localparam GAP_UNIT_CYCLES = (GAP_UNIT_NS + CLK_NS - 1) / CLK_NS;

  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_WTRIG = 3'd1;
  localparam [2:0] S_START = 3'd2;
  localparam [2:0] S_CONV  = 3'd3;
  localparam [2:0] S_GAP   = 3'd4;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  reg  [1:0]  trigger_source_select;
  reg  [2:0]  auto_count_select;
  reg         two_channel;
  reg  [3:0]  channel_gap_time;
  reg         auto_go_bit;
  reg         delay_timer_run;
  reg         retrigger_overrun_flag;
  reg  [15:0] delay_timer_preload;
  reg  [2:0]  state;
  reg  [4:0]  done_cnt;
  reg         stop_req;
  reg         busy_s1;
  reg         busy_s2;
  reg         busy_d;

  wire [15:0] tmr_count;
  wire        tmr_ovf;
  wire        gap_done;
  wire        acc;
  wire        wr;
  wire        wr_ctrl;
  wire        wr_pre;
  wire        wr_stat;
  wire        mapped;
  wire        busy_fall;
  wire        busy_rise;
  wire        src_delay;
  wire        go_start;
  wire        go_stop;
  wire [4:0]  n_target;
  wire [4:0]  done_next;
  wire        working;
  reg  [31:0] rd_mux;

  // ------------------------------------------------------------------
  // Count select decode
  // ------------------------------------------------------------------
  function [4:0] n_of;
    input [2:0] code;
    begin
      case (code)
        3'b001:  n_of = 5'd1;
        3'b010:  n_of = 5'd2;
        3'b011:  n_of = 5'd4;
        3'b100:  n_of = 5'd8;
        default: n_of = 5'd16;
      endcase
    end
  endfunction

  assign n_target  = n_of(auto_count_select);
  assign done_next = done_cnt + 5'd1;
  assign src_delay = (trigger_source_select == `ADCSEQ_SRC_DELAY);
  assign working   = (state == S_START) || (state == S_CONV) ||
                     (state == S_GAP);

  // ------------------------------------------------------------------
  // Busy synchroniser; only the second stage and its delayed copy busy_d feed logic
  // ------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      busy_d  <= 1'b0;
    end else begin
      busy_s1 <= conv_busy_pin;
      busy_s2 <= busy_s1;
      busy_d  <= busy_s2;
    end
  end

  assign busy_fall = busy_d && !busy_s2;
  assign busy_rise = !busy_d && busy_s2;

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  assign mapped  = (paddr == `ADCSEQ_CTRL_OFS) ||
                   (paddr == `ADCSEQ_PRELOAD_OFS) ||
                   (paddr == `ADCSEQ_STATUS_OFS) ||
                   (paddr == `ADCSEQ_TIMER_OFS);
  assign acc     = psel && penable && pready;
  assign wr      = acc && pwrite && mapped;
  assign wr_ctrl = wr && (paddr == `ADCSEQ_CTRL_OFS);
  assign wr_pre  = wr && (paddr == `ADCSEQ_PRELOAD_OFS);
  assign wr_stat = wr && (paddr == `ADCSEQ_STATUS_OFS);

  // A start needs idle, a covered source and a nonzero count code
  assign go_start = wr_ctrl && pwdata[`ADCSEQ_GO_BIT] && !auto_go_bit &&
                    (state == S_IDLE) &&
                    pwdata[`ADCSEQ_SRC_MSB] &&
                    (pwdata[`ADCSEQ_CNT_MSB:`ADCSEQ_CNT_LSB] !=
                     `ADCSEQ_CNT_MANUAL);
  assign go_stop  = wr_ctrl && !pwdata[`ADCSEQ_GO_BIT] && auto_go_bit;

  always @* begin
    case (paddr)
      `ADCSEQ_CTRL_OFS:
        rd_mux = {14'h0000, delay_timer_run, auto_go_bit, 4'h0,
                  channel_gap_time, 2'b00, two_channel,
                  auto_count_select, trigger_source_select};
      `ADCSEQ_PRELOAD_OFS:
        rd_mux = {16'h0000, delay_timer_preload};
      `ADCSEQ_STATUS_OFS:
        rd_mux = {19'h00000, done_cnt, 3'b000, busy_s2, adc_irq,
                  retrigger_overrun_flag, delay_timer_run, auto_go_bit};
      `ADCSEQ_TIMER_OFS:
        rd_mux = {16'h0000, tmr_count};
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  // One wait-free access: ready comes up in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable) begin
        prdata <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------------
  // Configuration registers; mode is frozen while a group runs
  // ------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_source_select <= `ADCSEQ_SRC_RST;
      auto_count_select     <= `ADCSEQ_CNT_RST;
      two_channel           <= 1'b0;
      channel_gap_time      <= `ADCSEQ_GAP_RST;
      delay_timer_preload   <= `ADCSEQ_PRELOAD_RST;
    end else begin
      if (wr_ctrl && !auto_go_bit) begin
        trigger_source_select <= pwdata[`ADCSEQ_SRC_MSB:`ADCSEQ_SRC_LSB];
        auto_count_select     <= pwdata[`ADCSEQ_CNT_MSB:`ADCSEQ_CNT_LSB];
        two_channel           <= pwdata[`ADCSEQ_TWOCH_BIT];
        channel_gap_time      <= pwdata[`ADCSEQ_GAP_MSB:`ADCSEQ_GAP_LSB];
      end
      if (wr_pre) begin
        delay_timer_preload <= pwdata[15:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Timers
  // ------------------------------------------------------------------
  adcseq_delay_timer #(
    .WIDTH      (16)
  ) u_delay (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (delay_timer_run),
    .load       (wr_pre && !delay_timer_run),
    .load_value (pwdata[15:0]),
    .preload    (delay_timer_preload),
    .count      (tmr_count),
    .overflow   (tmr_ovf)
  );

  adcseq_gap_timer #(
    .UNIT_CYCLES (GAP_UNIT_CYCLES)
  ) u_gap (
    .pclk        (pclk),
    .presetn     (presetn),
    .run         (state == S_GAP),
    .gap         (channel_gap_time),
    .done        (gap_done)
  );

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= S_IDLE;
      auto_go_bit            <= 1'b0;
      delay_timer_run        <= 1'b0;
      retrigger_overrun_flag <= 1'b0;
      adc_irq                <= 1'b0;
      done_cnt               <= 5'd0;
      stop_req               <= 1'b0;
      conv_start             <= 1'b0;
      conv_channel           <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      // Software side: run bit write and write-one-to-clear flags
      if (wr_ctrl) begin
        delay_timer_run <= pwdata[`ADCSEQ_RUN_BIT];
      end
      if (wr_stat && pwdata[`ADCSEQ_ST_OVR_BIT]) begin
        retrigger_overrun_flag <= 1'b0;
      end
      if (wr_stat && pwdata[`ADCSEQ_ST_IRQ_BIT]) begin
        adc_irq <= 1'b0;
      end
      // Overflow while work is in progress is dropped and flagged
      if (src_delay && tmr_ovf && auto_go_bit && working) begin
        retrigger_overrun_flag <= 1'b1;
      end
      if (go_start) begin
        auto_go_bit            <= 1'b1;
        retrigger_overrun_flag <= 1'b0;
        done_cnt               <= 5'd0;
        stop_req               <= 1'b0;
        if (pwdata[`ADCSEQ_SRC_MSB:`ADCSEQ_SRC_LSB] == `ADCSEQ_SRC_DELAY) begin
          delay_timer_run <= 1'b1;
          state           <= S_WTRIG;
        end else begin
          conv_start   <= 1'b1;
          conv_channel <= 1'b0;
          state        <= S_START;
        end
      end else if (go_stop && (state != S_START) && (state != S_CONV)) begin
        auto_go_bit <= 1'b0;
        state       <= S_IDLE;
        done_cnt    <= 5'd0;
      end else begin
        // A stop while converting must not swallow a busy edge
        if (go_stop) begin
          auto_go_bit <= 1'b0;
          stop_req    <= 1'b1;
        end
        case (state)
          S_IDLE: begin
            stop_req <= 1'b0;
          end
          S_WTRIG: begin
            if (tmr_ovf) begin
              conv_start   <= 1'b1;
              conv_channel <= 1'b0;
              state        <= S_START;
            end
          end
          S_START: begin
            if (busy_rise) begin
              state <= S_CONV;
            end
          end
          S_CONV: begin
            if (busy_fall) begin
              if (stop_req || go_stop) begin
                // Deferred reset once the running conversion ends
                state    <= S_IDLE;
                done_cnt <= 5'd0;
                stop_req <= 1'b0;
              end else if (two_channel && !conv_channel) begin
                state        <= S_GAP;
              end else begin
                done_cnt     <= done_next;
                if (done_next == n_target) begin
                  auto_go_bit <= 1'b0;
                  adc_irq     <= 1'b1;
                  if (src_delay) begin
                    delay_timer_run <= 1'b0;
                  end
                  state <= S_IDLE;
                end else if (src_delay) begin
                  state <= S_WTRIG;
                end else begin
                  state <= S_GAP;
                end
              end
            end
          end
          S_GAP: begin
            if (gap_done) begin
              conv_start   <= 1'b1;
              conv_channel <= two_channel && !conv_channel;
              state        <= S_START;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // adcseq_sequencer

`default_nettype wire

// ---- adcseq_props.sv ----
// Concurrent checks on the ports of the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adcseq_regs.vh"
module adcseq_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_busy_pin,
  input wire logic        conv_start,
  input wire logic        conv_channel,
  input wire logic        adc_irq
);
  // --------
  // Properties
  // --------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Clear strobe taken loosely, so a stalled access never trips the check
  wire irq_clr = psel && penable && pwrite &&
                 paddr == `ADCSEQ_STATUS_OFS && pwdata[`ADCSEQ_ST_IRQ_BIT];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_quiet;
    !conv_start [*3];
  endsequence
  a_pready_setup: assert property (s_setup |=> pready && psel && penable)
    else $error("pready missing after setup");
  a_slverr_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer with data");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_start_idle: assert property (conv_start |-> !conv_busy_pin)
    else $error("start while converter busy");
  a_start_after_fall: assert property (
    $fell(conv_busy_pin) |-> s_quiet)
    else $error("start too soon after completion");
  a_chan_hold: assert property (!conv_start |-> $stable(conv_channel))
    else $error("channel moved without a start");
  a_ch2_after_ch1: assert property (
    conv_start && conv_channel |-> !$past(conv_channel))
    else $error("second channel without first");
  a_irq_idle: assert property ($rose(adc_irq) |-> !conv_busy_pin)
    else $error("interrupt while converting");
  a_irq_sticky: assert property (adc_irq && !irq_clr |=> adc_irq)
    else $error("interrupt dropped without clear");
endmodule // adcseq_props
bind adcseq_sequencer adcseq_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .conv_busy_pin(conv_busy_pin),
  .conv_start(conv_start), .conv_channel(conv_channel), .adc_irq(adc_irq)
);
`default_nettype wire

// ---- adcseq_conv_model.sv ----
// Behavioural converter core answering start pulses with a busy window
`timescale 1ns/100ps
`default_nettype none
module adcseq_conv_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        conv_start,
  input  wire logic        conv_channel,
  input  wire logic [7:0]  conv_len,
  output wire logic        conv_busy_pin,
  output var  logic [15:0] n_starts,
  output var  logic [15:0] n_ch2,
  output var  logic [15:0] start_gap
);
  logic [7:0]  left;
  logic [15:0] since;
  // Busy rises the cycle after start and holds conv_len cycles
  assign conv_busy_pin = (left != 8'h00);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 8'h00;
      since <= 16'h0000;
      n_starts <= 16'h0000;
      n_ch2 <= 16'h0000;
      start_gap <= 16'h0000;
    end else begin
      since <= since + 16'h0001;
      if (left != 8'h00) begin
        left <= left - 8'h01;
      end
      if (conv_start) begin
        left <= conv_len;
        since <= 16'h0000;
        start_gap <= since + 16'h0001;
        n_starts <= n_starts + 16'h0001;
        n_ch2 <= n_ch2 + {15'h0000, conv_channel};
      end
    end
  end
endmodule // adcseq_conv_model
`default_nettype wire

// ---- adcseq_sequencer_tb.sv ----
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
`include "adcseq_regs.vh"
module adcseq_sequencer_tb;
  logic        pclk, presetn, psel, penable, pwrite, rerr;
  logic [7:0]  paddr, conv_len;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, conv_busy_pin, conv_start, conv_channel;
  logic        adc_irq;
  logic [15:0] n_starts, n_ch2, start_gap;
  int          err_total, checks;
  int          nval [8] = '{0, 1, 2, 4, 8, 16, 16, 16};

  adcseq_sequencer u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_busy_pin(conv_busy_pin),
    .conv_start(conv_start), .conv_channel(conv_channel), .adc_irq(adc_irq)
  );
  adcseq_conv_model u_core (
    .pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_len(conv_len),
    .conv_busy_pin(conv_busy_pin), .n_starts(n_starts), .n_ch2(n_ch2),
    .start_gap(start_gap)
  );

  // --------
  // Shared tasks
  // --------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // An idle cycle after each access keeps one assignment per time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (i >= 40) begin
      err_total++;
      summarize();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Waits for the interrupt (sel high) or for converter busy (sel low)
  task automatic wait_hi(input logic irq_sel);
    int i;
    for (i = 0; i < 5000 && (irq_sel ? adc_irq : conv_busy_pin) !== 1'b1;
         i++) begin
      @(posedge pclk);
    end
    if (i >= 5000) begin
      err_total++;
      summarize();
    end
  endtask
  // One group: start, count starts, check flags, clear the interrupt
  task automatic run_grp(input logic [31:0] ctrl, input logic [15:0] pre,
                         input logic [7:0] len, input int n, input int c2,
                         input int gap, input logic ovr);
    logic [15:0] s0, h0;
    conv_len <= len;
    s0 = n_starts;
    h0 = n_ch2;
    apb(1'b1, `ADCSEQ_PRELOAD_OFS, {16'h0000, pre});
    apb(1'b1, `ADCSEQ_CTRL_OFS, ctrl | 32'h10000);
    if (ctrl[1:0] == 2'b11) begin
      apb(1'b1, `ADCSEQ_CTRL_OFS, (ctrl & ~32'h1c) | 32'h10004);
    end
    apb(1'b0, `ADCSEQ_STATUS_OFS, 32'h0);
    chk({30'h0, rd[2:1]}, {31'h0, ctrl[1:0] == 2'b10});
    wait_hi(1'b1);
    chk(32'(n_starts - s0), 32'(n));
    chk(32'(n_ch2 - h0), 32'(c2));
    if (gap != 0) begin
      chk(32'(start_gap), 32'(gap));
    end
    apb(1'b0, `ADCSEQ_STATUS_OFS, 32'h0);
    chk({rd[12:8], rd[3:0]}, {5'(n - c2), 1'b1, ovr, 2'b00});
    apb(1'b1, `ADCSEQ_CTRL_OFS, ctrl);
    chk(adc_irq, 1'b1);
    apb(1'b1, `ADCSEQ_STATUS_OFS, 32'hc);
    chk(adc_irq, 1'b0);
  endtask

  // --------
  // Stimulus
  // --------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    int c;
    logic [15:0] s;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    conv_len = 8'h06;
    err_total = 0;
    checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `ADCSEQ_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], rerr}, 32'h1);
    // Free-running stop in mid-conversion, then check that no further start follows
    conv_len <= 8'h14;
    apb(1'b1, `ADCSEQ_CTRL_OFS, 32'h10117);
    wait_hi(1'b0);
    s = n_starts;
    apb(1'b1, `ADCSEQ_CTRL_OFS, 32'h117);
    repeat (60) @(posedge pclk);
    chk(32'(n_starts), 32'(s));
    apb(1'b0, `ADCSEQ_STATUS_OFS, 32'h0);
    chk({rd[12:8], rd[3], rd[0]}, 32'h0);
    // Timer-delay stop while converting, manual code, back to automatic
    apb(1'b1, `ADCSEQ_PRELOAD_OFS, 32'hfff0);
    apb(1'b1, `ADCSEQ_CTRL_OFS, 32'h10016);
    wait_hi(1'b0);
    s = n_starts;
    apb(1'b1, `ADCSEQ_CTRL_OFS, 32'h16);
    repeat (40) @(posedge pclk);
    apb(1'b1, `ADCSEQ_CTRL_OFS, 32'h2);
    apb(1'b1, `ADCSEQ_CTRL_OFS, 32'h16);
    repeat (40) @(posedge pclk);
    chk(32'(n_starts), 32'(s));
    apb(1'b0, `ADCSEQ_STATUS_OFS, 32'h0);
    chk({rd[12:8], rd[3:0]}, 32'h0);
    for (c = 1; c < 8; c++) begin
      run_grp(32'h103 | (c << 2), 16'h0, 8'h06, nval[c], 0, 0, 1'b0);
    end
    run_grp(32'h12b, 16'h0, 8'h06, 4, 2, 0, 1'b0);
    run_grp(32'h00a, 16'hfff0, 8'h1e, 2, 0, 0, 1'b1);
    run_grp(32'h00a, 16'hfff0, 8'h04, 2, 0, 16, 1'b0);
    run_grp(32'h126, 16'hffc0, 8'h04, 2, 1, 0, 1'b0);
    summarize();
  end
endmodule // adcseq_sequencer_tb
`default_nettype wire
